/* fcc_flash_ctrl.v */
// host controller driving a parallel command-set flash
`timescale 1ns/100ps
`include "fcc_consts.vh"
// Notes on behaviour
// - data read only with chip and output enable low
// - hold reset low at least minimum pulse
// - wait recovery after reset, reissue interrupted operation (the controller reissues nothing after a reset)
// - three-cycle or single-cycle exit leaves id mode
// - single F0 write exits id mode
// - sector addresses 03XXX, 05XXX, 1FXXX
module fcc_flash_ctrl #(
    parameter POWERON_CYC = `FCC_POWERON_CYC,
    parameter PROG_CYC = `FCC_PROG_CYC,
    parameter ERASE_TIMEOUT_CYC = 32'd50000000
) (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire i_clk_en,
    input wire i_req,
    input wire [2:0] i_op,
    input wire [16:0] i_addr,
    input wire [15:0] i_wdata,
    input wire i_flash_rst_req,
    input wire [15:0] i_data_pins_in,
    output reg o_ready,
    output reg o_done,
    output reg o_error,
    output reg [15:0] o_rdata,
    output reg o_flash_ce_n,
    output reg o_flash_oe_n,
    output reg o_flash_we_n,
    output reg o_flash_reset_n,
    output reg [16:0] o_word_address,
    output reg [15:0] o_data_pins_out,
    output reg o_data_pins_oe
);
    // ****************************************************
    // states
    // ****************************************************
    localparam ST_IDLE = 7'h01;
    localparam ST_SEQ = 7'h02;
    localparam ST_POLL = 7'h04;
    localparam ST_RST = 7'h08;
    localparam ST_RECOV = 7'h10;
    localparam ST_READ = 7'h20;
    localparam ST_FIN = 7'h40;
    reg [6:0] state;
    reg [2:0] op;
    reg [16:0] addr;
    reg [15:0] wdata;
    reg [2:0] step;
    reg [31:0] tmr;
    reg [31:0] pon;
    reg have_prev;
    reg [15:0] prev;
    reg cyc_start;
    reg cyc_write;
    reg [16:0] cyc_addr;
    reg [15:0] cyc_data;
    wire cyc_busy;
    wire cyc_done;
    wire [15:0] cyc_rdata;
    wire [16:0] p_addr;
    wire [15:0] p_dq;
    wire p_oe;
    wire p_ce_n;
    wire p_oen;
    wire p_wen;
    // number of write cycles each operation except read issues
    function [2:0] seq_len;
        input [2:0] o;
        begin
            case (o)
                `FCC_OP_PROG: seq_len = 3'd4;
                `FCC_OP_CHIP_ERASE,
                `FCC_OP_SECT_ERASE,
                `FCC_OP_LOCKOUT: seq_len = 3'd6;
                `FCC_OP_ID_EXIT1: seq_len = 3'd1;
                default: seq_len = 3'd3;
            endcase
        end
    endfunction
    // ****************************************************
    // pin cycle engine
    // ****************************************************
    fcc_bus_cycle #(
        .WE_CYC(`FCC_WE_LOW_CYC),
        .RD_CYC(`FCC_RD_CYC)
    ) u_cyc (
        .i_core_clk(i_core_clk),
        .i_rst_n(i_rst_n),
        .i_ce(i_clk_en),
        .i_start(cyc_start),
        .i_write(cyc_write),
        .i_addr(cyc_addr),
        .i_data(cyc_data),
        .i_dq_in(i_data_pins_in),
        .o_busy(cyc_busy),
        .o_done(cyc_done),
        .o_rdata(cyc_rdata),
        .o_addr(p_addr),
        .o_dq_out(p_dq),
        .o_dq_oe(p_oe),
        .o_ce_n(p_ce_n),
        .o_oe_n(p_oen),
        .o_we_n(p_wen)
    );
    // ****************************************************
    // address and data of each sequence step
    // ****************************************************
    reg [16:0] s_addr;
    reg [15:0] s_data;
    always @* begin
        s_addr = `FCC_UNLOCK_ADDR1;
        s_data = `FCC_UNLOCK_DATA1;
        if (op == `FCC_OP_ID_EXIT1) begin
            s_addr = addr;
            s_data = `FCC_CMD_ID_EXIT;
        end else begin
            case (step)
                3'd1, 3'd4: begin
                    s_addr = `FCC_UNLOCK_ADDR2;
                    s_data = `FCC_UNLOCK_DATA2;
                end
                3'd2: begin
                    case (op)
                        `FCC_OP_PROG: s_data = `FCC_CMD_PROGRAM;
                        `FCC_OP_ID_ENTRY: s_data = `FCC_CMD_ID_ENTRY;
                        `FCC_OP_ID_EXIT3: s_data = `FCC_CMD_ID_EXIT;
                        default: s_data = `FCC_CMD_ERASE_SETUP;
                    endcase
                end
                3'd3: begin
                    if (op == `FCC_OP_PROG) begin
                        s_addr = addr;
                        s_data = wdata;
                    end
                end
                3'd5: begin
                    case (op)
                        `FCC_OP_SECT_ERASE: begin
                            s_addr = addr;
                            s_data = `FCC_CMD_SECT_ERASE;
                        end
                        `FCC_OP_LOCKOUT: s_data = `FCC_CMD_LOCKOUT;
                        default: s_data = `FCC_CMD_CHIP_ERASE;
                    endcase
                end
                default: s_data = `FCC_UNLOCK_DATA1;
            endcase
        end
    end
    wire is_erase = (op == `FCC_OP_CHIP_ERASE) || (op == `FCC_OP_SECT_ERASE);
    wire needs_poll = is_erase || (op == `FCC_OP_PROG);
    wire pon_done = (pon == 32'd0);
    // erased words read all ones; program target reads its data
    wire [15:0] poll_target = is_erase ? 16'hFFFF : wdata;
    // ****************************************************
    // sequencer
    // ****************************************************
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= ST_RST;
            op <= `FCC_OP_READ;
            addr <= 17'h00000;
            wdata <= 16'h0000;
            step <= 3'd0;
            tmr <= 32'd0;
            pon <= 32'd0;
            have_prev <= 1'b0;
            prev <= 16'h0000;
            cyc_start <= 1'b0;
            cyc_write <= 1'b0;
            cyc_addr <= 17'h00000;
            cyc_data <= 16'h0000;
            o_ready <= 1'b0;
            o_done <= 1'b0;
            o_error <= 1'b0;
            o_rdata <= 16'h0000;
            o_flash_reset_n <= 1'b0;
            o_flash_ce_n <= 1'b1;
            o_flash_oe_n <= 1'b1;
            o_flash_we_n <= 1'b1;
            o_word_address <= 17'h00000;
            o_data_pins_out <= 16'h0000;
            o_data_pins_oe <= 1'b0;
        end else if (i_clk_en) begin
            // select and data outlast the write strobe's rise by a cycle
            o_flash_ce_n <= p_ce_n && o_flash_we_n;
            o_flash_oe_n <= p_oen;
            o_flash_we_n <= p_wen;
            o_word_address <= p_addr;
            o_data_pins_out <= p_dq;
            o_data_pins_oe <= p_oe || !o_flash_we_n;
            cyc_start <= 1'b0;
            o_done <= 1'b0;
            if (!pon_done)
                pon <= pon - 32'd1;
            case (state)
                ST_IDLE: begin
                    if (i_flash_rst_req) begin
                        o_ready <= 1'b0;
                        tmr <= 32'd0;
                        state <= ST_RST;
                    end else if (i_req) begin
                        o_ready <= 1'b0;
                        o_error <= 1'b0;
                        op <= i_op;
                        addr <= i_addr;
                        wdata <= i_wdata;
                        step <= 3'd0;
                        have_prev <= 1'b0;
                        tmr <= 32'd0;
                        state <= (i_op == `FCC_OP_READ) ? ST_READ : ST_SEQ;
                    end
                end
                ST_RST: begin
                    o_flash_reset_n <= 1'b0;
                    tmr <= tmr + 32'd1;
                    if (tmr >= `FCC_RST_PULSE_CYC) begin
                        o_flash_reset_n <= 1'b1;
                        tmr <= 32'd0;
                        state <= ST_RECOV;
                    end
                end
                ST_RECOV: begin
                    tmr <= tmr + 32'd1;
                    if (tmr >= `FCC_RST_RECOV_CYC) begin
                        if (pon == 32'd0 && !have_prev)
                            pon <= POWERON_CYC;
                        have_prev <= 1'b1;
                        o_ready <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                ST_READ: begin
                    if (!cyc_busy && !cyc_start && !cyc_done) begin
                        cyc_start <= 1'b1;
                        cyc_write <= 1'b0;
                        cyc_addr <= addr;
                    end
                    if (cyc_done) begin
                        o_rdata <= cyc_rdata;
                        state <= ST_FIN;
                    end
                end
                ST_SEQ: begin
                    if (needs_poll && !pon_done) begin
                    end else if (!cyc_busy && !cyc_start && !cyc_done) begin
                        cyc_start <= 1'b1;
                        cyc_write <= 1'b1;
                        cyc_addr <= s_addr;
                        cyc_data <= s_data;
                    end else if (cyc_done) begin
                        if (step == seq_len(op) - 3'd1) begin
                            tmr <= 32'd0;
                            state <= needs_poll ? ST_POLL : ST_FIN;
                        end else begin
                            step <= step + 3'd1;
                        end
                    end
                end
                ST_POLL: begin
                    tmr <= tmr + 32'd1;
                    if (!cyc_busy && !cyc_start && !cyc_done) begin
                        cyc_start <= 1'b1;
                        cyc_write <= 1'b0;
                        cyc_addr <= addr;
                    end
                    if (cyc_done) begin
                        have_prev <= 1'b1;
                        prev <= cyc_rdata;
                        // toggle stopped and poll bit equal to the target's poll bit means done
                        if (have_prev &&
                            prev[`FCC_TOGGLE_BIT] ==
                            cyc_rdata[`FCC_TOGGLE_BIT] &&
                            cyc_rdata[`FCC_POLL_BIT] ==
                            poll_target[`FCC_POLL_BIT]) begin
                            o_rdata <= cyc_rdata;
                            // locked boot words stay unchanged
                            o_error <= (cyc_rdata != poll_target) &&
                                !(op == `FCC_OP_SECT_ERASE);
                            state <= ST_FIN;
                        end else if (tmr >= (is_erase ? ERASE_TIMEOUT_CYC
                                     : PROG_CYC)) begin
                            o_error <= 1'b1;
                            o_rdata <= cyc_rdata;
                            state <= ST_FIN;
                        end
                    end
                end
                ST_FIN: begin
                    o_done <= 1'b1;
                    o_ready <= 1'b1;
                    state <= ST_IDLE;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end
endmodule // fcc_flash_ctrl

/* fcc_consts.vh */
// constants for the flash command controller
`ifndef FCC_CONSTS_VH
`define FCC_CONSTS_VH
// ****************************************************
// command operations requested on the user side
// ****************************************************
`define FCC_OP_READ 3'h0
`define FCC_OP_PROG 3'h1
`define FCC_OP_CHIP_ERASE 3'h2
`define FCC_OP_SECT_ERASE 3'h3
`define FCC_OP_LOCKOUT 3'h4
`define FCC_OP_ID_ENTRY 3'h5
`define FCC_OP_ID_EXIT3 3'h6
`define FCC_OP_ID_EXIT1 3'h7
// ****************************************************
// unlock addresses and command data
// ****************************************************
`define FCC_UNLOCK_ADDR1 17'h05555
`define FCC_UNLOCK_ADDR2 17'h02AAA
`define FCC_UNLOCK_DATA1 16'h00AA
`define FCC_UNLOCK_DATA2 16'h0055
`define FCC_CMD_ERASE_SETUP 16'h0080
`define FCC_CMD_CHIP_ERASE 16'h0010
`define FCC_CMD_SECT_ERASE 16'h0030
`define FCC_CMD_PROGRAM 16'h00A0
`define FCC_CMD_LOCKOUT 16'h0040
`define FCC_CMD_ID_ENTRY 16'h0090
`define FCC_CMD_ID_EXIT 16'h00F0
// ****************************************************
// address map
// ****************************************************
`define FCC_BOOT_LAST 17'h01FFF
`define FCC_SA_PARAM1 17'h03000
`define FCC_SA_PARAM2 17'h05000
`define FCC_SA_MAIN 17'h1F000
`define FCC_ID_MANUF_ADDR 17'h00000
`define FCC_ID_DEVICE_ADDR 17'h00001
`define FCC_ID_LOCK_ADDR 17'h00002
`define FCC_LOCK_BIT 0
`define FCC_POLL_BIT 7
`define FCC_TOGGLE_BIT 6
// ****************************************************
// timing in ns and derived cycles at 100 MHz
// ****************************************************
`define FCC_CLK_NS 10
`define FCC_WE_LOW_NS 15
`define FCC_WE_LOW_CYC ((`FCC_WE_LOW_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS + 1)
`define FCC_RD_NS 70
`define FCC_RD_CYC ((`FCC_RD_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS + 1)
`define FCC_RST_PULSE_NS 500
`define FCC_RST_PULSE_CYC ((`FCC_RST_PULSE_NS+`FCC_CLK_NS-1)/`FCC_CLK_NS)
`define FCC_RST_RECOV_NS 50
`define FCC_RST_RECOV_CYC ((`FCC_RST_RECOV_NS+`FCC_CLK_NS-1)/`FCC_CLK_NS)
`define FCC_POWERON_NS 5000000
`define FCC_POWERON_CYC ((`FCC_POWERON_NS+`FCC_CLK_NS-1)/`FCC_CLK_NS)
`define FCC_PROG_MAX_NS 50000
`define FCC_PROG_CYC (`FCC_PROG_MAX_NS / `FCC_CLK_NS)
`endif

/* fcc_bus_cycle.v */
// one write or read cycle on the flash pins
`timescale 1ns/100ps
module fcc_bus_cycle #(
    parameter WE_CYC = 3,
    parameter RD_CYC = 8
) (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire i_ce,
    input wire i_start,
    input wire i_write,
    input wire [16:0] i_addr,
    input wire [15:0] i_data,
    input wire [15:0] i_dq_in,
    output reg o_busy,
    output reg o_done,
    output reg [15:0] o_rdata,
    output reg [16:0] o_addr,
    output reg [15:0] o_dq_out,
    output reg o_dq_oe,
    output reg o_ce_n,
    output reg o_oe_n,
    output reg o_we_n
);
    reg [7:0] cnt;
    reg wr;
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
            o_done <= 1'b0;
            o_rdata <= 16'h0000;
            o_addr <= 17'h00000;
            o_dq_out <= 16'h0000;
            o_dq_oe <= 1'b0;
            o_ce_n <= 1'b1;
            o_oe_n <= 1'b1;
            o_we_n <= 1'b1;
            cnt <= 8'h00;
            wr <= 1'b0;
        end else if (i_ce) begin
            o_done <= 1'b0;
            if (!o_busy) begin
                if (i_start) begin
                    o_busy <= 1'b1;
                    wr <= i_write;
                    o_addr <= i_addr;
                    o_dq_out <= i_data;
                    // bus driven only for writes, oe held high then
                    o_dq_oe <= i_write;
                    o_ce_n <= 1'b0;
                    o_oe_n <= i_write;
                    o_we_n <= ~i_write;
                    cnt <= i_write ? WE_CYC[7:0] : RD_CYC[7:0];
                end
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end else begin
                if (!wr)
                    o_rdata <= i_dq_in;
                o_busy <= 1'b0;
                o_done <= 1'b1;
                o_ce_n <= 1'b1;
                o_oe_n <= 1'b1;
                o_we_n <= 1'b1;
                o_dq_oe <= 1'b0;
            end
        end
    end
endmodule // fcc_bus_cycle

/* fcc_flash_model.sv */
// behavioural model of the parallel flash device on the controller's pins
`timescale 1ns/100ps
module fcc_flash_model #(
    parameter PROG_T = 40,
    parameter ERASE_T = 90,
    parameter PON_T = 30,
    parameter HV_OVERRIDE = 0,
    parameter [15:0] MANUF_ID = 16'h0011, // arbitrary value
    parameter [15:0] DEV_ID = 16'h0022 // arbitrary value
) (
    input wire i_clk,
    input wire i_ce_n,
    input wire i_oe_n,
    input wire i_we_n,
    input wire i_reset_n,
    input wire [16:0] i_addr,
    input wire [15:0] i_dq,
    output logic [15:0] o_dq,
    output logic o_dq_oe
);
    logic [15:0] mem [int];
    logic [2:0] step = 3'h0;
    logic id_mode = 1'b0;
    logic locked = 1'b0;
    logic erasing = 1'b0;
    logic tog = 1'b0;
    logic [16:0] fall_a = 17'h00000;
    logic [15:0] last_d = 16'h0000;
    int busy = 0;
    int pon = PON_T;
    realtime t_fall = 0;
    function automatic logic [15:0] rd(int a);
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction
    task automatic wipe(int lo, int hi);
        for (int a = lo; a <= hi; a++) mem.delete(a);
    endtask
    task automatic six(logic [16:0] a, logic [7:0] c);
        if (pon > 0) return;
        if (a == 17'h05555 && c == 8'h40) locked = 1'b1;
        if (a == 17'h05555 && c == 8'h10)
            wipe(locked ? 'h2000 : 0, 'h1FFFF);
        if (c == 8'h30) begin
            // sector chosen by the top address bits
            if (a[16:12] == 5'h03) wipe('h2000, 'h3FFF);
            if (a[16:12] == 5'h05) wipe('h4000, 'h5FFF);
            if (a[16:12] == 5'h1F) wipe('h6000, 'h1FFFF);
            if (a[16:12] == 5'h1F && !locked) wipe(0, 'h1FFF);
        end
        if (c == 8'h10 || c == 8'h30) begin
            erasing = 1'b1;
            busy = ERASE_T;
        end
    endtask
    task automatic take(logic [16:0] a, logic [15:0] d);
        if (d[7:0] == 8'hF0 && step != 3'h6) begin
            id_mode = 1'b0;
            step = 3'h0;
        end else case (step)
            3'h0, 3'h3: step = (a == 17'h05555 && d[7:0] == 8'hAA) ? step + 3'h1 : 3'h0;
            3'h1, 3'h4: step = (a == 17'h02AAA && d[7:0] == 8'h55) ? step + 3'h1 : 3'h0;
            3'h2: begin
                step = (a == 17'h05555 && d[7:0] == 8'h80) ? 3'h3 : 3'h0;
                if (a == 17'h05555 && d[7:0] == 8'hA0) step = 3'h6;
                if (a == 17'h05555 && d[7:0] == 8'h90) id_mode = 1'b1;
            end
            3'h5: begin
                step = 3'h0;
                six(a, d[7:0]);
            end
            3'h6: begin
                step = 3'h0;
                // locked boot words and the power-on delay refuse programming
                if (pon == 0 && !(locked && !HV_OVERRIDE &&
                        a <= 17'h01FFF)) begin
                    mem[int'(a)] = rd(int'(a)) & d;
                    last_d = d;
                    erasing = 1'b0;
                    busy = PROG_T;
                end
            end
            default: step = 3'h0;
        endcase
    endtask
    always @(posedge i_clk) begin
        if (pon > 0) pon = pon - 1;
        if (busy > 0) busy = busy - 1;
    end
    always @(negedge i_reset_n) begin
        step = 3'h0;
        id_mode = 1'b0;
        busy = 0;
    end
    always @(negedge i_we_n) begin
        t_fall = $realtime;
        fall_a = i_addr;
    end
    always @(posedge i_we_n) begin
        if (!i_ce_n && i_oe_n && i_reset_n && busy == 0 &&
            $realtime - t_fall >= 15)
            take(fall_a, i_dq);
    end
    always @(negedge i_oe_n) begin
        if (busy > 0) tog = ~tog;
    end
    always @(i_addr, i_ce_n, i_oe_n, i_reset_n, busy, tog, id_mode) begin
        o_dq_oe = !i_ce_n && !i_oe_n && i_reset_n;
        if (busy > 0)
            o_dq = {8'h00, !erasing && !last_d[7], tog, 6'h00};
        else if (id_mode && i_addr == 17'h00000) o_dq = MANUF_ID;
        else if (id_mode && i_addr == 17'h00001) o_dq = DEV_ID;
        else if (id_mode && i_addr == 17'h00002) o_dq = {15'h0000, locked};
        else o_dq = rd(int'(i_addr));
    end
endmodule // fcc_flash_model

/* fcc_flash_ctrl_properties.sv */
// pin-level and handshake properties of the flash command controller
`timescale 1ns/100ps
module fcc_ctrl_props (
    input wire i_core_clk,
    input wire i_rst_n,
    input wire i_clk_en,
    input wire i_req,
    input wire o_ready,
    input wire o_done,
    input wire o_flash_ce_n,
    input wire o_flash_oe_n,
    input wire o_flash_we_n,
    input wire o_flash_reset_n,
    input wire [16:0] o_word_address,
    input wire [15:0] o_data_pins_out,
    input wire o_data_pins_oe
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    logic [7:0] rst_low;
    always @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) rst_low <= 8'h00;
        else if (o_flash_reset_n) rst_low <= 8'h00;
        else if (rst_low != 8'hFF) rst_low <= rst_low + 8'h01;
    end
    AST_READ_GATE: assert property (!o_flash_oe_n |-> !o_flash_ce_n &&
        o_flash_we_n && !o_data_pins_oe) else $error("bad read strobes");
    AST_WRITE_GATE: assert property (!o_flash_we_n |-> !o_flash_ce_n &&
        o_flash_oe_n && o_data_pins_oe) else $error("bad write strobes");
    AST_NO_CONTEND: assert property (o_data_pins_oe |-> o_flash_oe_n)
        else $error("host drives pins during read");
    AST_WE_WIDTH: assert property ($fell(o_flash_we_n) |->
        !o_flash_we_n [*3]) else $error("write pulse too short");
    AST_WRITE_HOLD: assert property (!o_flash_we_n && $past(!o_flash_we_n)
        |-> $stable(o_word_address) && $stable(o_data_pins_out))
        else $error("address or data moved in write pulse");
    AST_RST_WIDTH: assert property ($rose(o_flash_reset_n) |->
        rst_low >= 8'h30) else $error("flash reset pulse too short");
    AST_RST_RECOV: assert property ($rose(o_flash_reset_n) |->
        o_flash_ce_n [*5]) else $error("access within reset recovery");
    AST_RST_FLOAT: assert property (!o_flash_reset_n |-> o_flash_ce_n &&
        o_flash_we_n && !o_data_pins_oe) else $error("pins active in reset");
    AST_DONE_PULSE: assert property (o_done |=> !o_done)
        else $error("done longer than one cycle");
    AST_TAKE: assert property (o_ready && i_req && i_clk_en |=> !o_ready)
        else $error("ready stayed high after take");
endmodule // fcc_ctrl_props
bind fcc_flash_ctrl fcc_ctrl_props i_props (.i_core_clk, .i_rst_n, .i_clk_en,
    .i_req, .o_ready, .o_done, .o_flash_ce_n, .o_flash_oe_n, .o_flash_we_n,
    .o_flash_reset_n, .o_word_address, .o_data_pins_out, .o_data_pins_oe);

/* tb.sv */
// self-checking testbench for the flash command controller
`timescale 1ns/100ps
module tb;
    localparam [15:0] MANUF = 16'h0011; // arbitrary value
    localparam [15:0] DEV = 16'h0022; // arbitrary value
    logic i_core_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_req = 1'b0;
    logic i_clk_en = 1'b1;
    logic [2:0] i_op = 3'h0;
    logic [16:0] i_addr = 17'h00000;
    logic [15:0] i_wdata = 16'h0000;
    logic i_flash_rst_req = 1'b0;
    logic [15:0] dq_last = 16'h0000;
    wire [15:0] i_data_pins_in, o_rdata, o_data_pins_out, f_dq;
    wire [16:0] o_word_address;
    wire o_ready, o_done, o_error, o_flash_ce_n, o_flash_oe_n, o_flash_we_n;
    wire o_flash_reset_n, o_data_pins_oe, f_oe;
    int bad_count = 0;
    int check_count = 0;
    always #5 i_core_clk = ~i_core_clk;
    // undriven pins show a pattern that changes every cycle
    assign i_data_pins_in = o_data_pins_oe ? o_data_pins_out :
        (f_oe ? f_dq : ~dq_last);
    always @(posedge i_core_clk) dq_last <= i_data_pins_in;
    fcc_flash_ctrl #(.POWERON_CYC(20), .PROG_CYC(300),
        .ERASE_TIMEOUT_CYC(2000)) i_dut (.i_core_clk, .i_rst_n,
        .i_clk_en, .i_req, .i_op, .i_addr, .i_wdata, .i_flash_rst_req,
        .i_data_pins_in, .o_ready, .o_done, .o_error, .o_rdata, .o_flash_ce_n,
        .o_flash_oe_n, .o_flash_we_n, .o_flash_reset_n, .o_word_address,
        .o_data_pins_out, .o_data_pins_oe);
    fcc_flash_model #(.MANUF_ID(MANUF), .DEV_ID(DEV)) i_flash (
        .i_clk(i_core_clk), .i_ce_n(o_flash_ce_n), .i_oe_n(o_flash_oe_n),
        .i_we_n(o_flash_we_n), .i_reset_n(o_flash_reset_n),
        .i_addr(o_word_address), .i_dq(i_data_pins_in), .o_dq(f_dq),
        .o_dq_oe(f_oe));
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic fail(string what);
        bad_count++;
        $display("CHECK FAILED at %0t: timeout on %s", $time, what);
        results();
    endtask
    task automatic chk(logic [15:0] got, logic [15:0] exp, string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask
    task automatic op(logic [2:0] code, logic [16:0] a, logic [15:0] d);
        int n;
        n = 0;
        while (o_ready !== 1'b1) begin
            @(negedge i_core_clk);
            if (++n > 5000) fail("ready");
        end
        @(posedge i_core_clk);
        i_req <= 1'b1;
        i_op <= code;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_core_clk);
        i_req <= 1'b0;
        n = 0;
        do begin
            @(negedge i_core_clk);
            if (++n > 20000) fail("done");
        end while (o_done !== 1'b1);
    endtask
    task automatic rd_chk(logic [16:0] a, logic [15:0] exp);
        op(3'h0, a, 16'h0000);
        chk(o_rdata, exp, "read word");
    endtask
    task automatic t_program();
        rd_chk(17'h06000, 16'hFFFF);
        op(3'h1, 17'h06000, 16'h1234);
        chk({15'h0000, o_error}, 16'h0000, "program error");
        rd_chk(17'h06000, 16'h1234);
        op(3'h1, 17'h06000, 16'h00FF);
        chk({15'h0000, o_error}, 16'h0001, "zero to one error");
        rd_chk(17'h06000, 16'h0034);
    endtask
    task automatic t_ident(logic lk, logic [2:0] exit_op);
        op(3'h5, 17'h00000, 16'h0000);
        rd_chk(17'h00000, MANUF);
        rd_chk(17'h00001, DEV);
        op(3'h0, 17'h00002, 16'h0000);
        chk({15'h0000, o_rdata[0]}, {15'h0000, lk}, "lock flag");
        op(exit_op, 17'h12345, 16'h0000);
        rd_chk(17'h00000, lk ? 16'h5A5A : 16'hFFFF);
    endtask
    task automatic t_main_erase(logic lk);
        op(3'h3, 17'h1F000, 16'h0000);
        rd_chk(17'h00100, lk ? 16'h5A5A : 16'hFFFF);
        rd_chk(17'h06000, 16'hFFFF);
    endtask
    task automatic t_lock();
        op(3'h1, 17'h00000, 16'h5A5A);
        op(3'h1, 17'h00100, 16'h5A5A);
        op(3'h4, 17'h00000, 16'h0000);
        t_ident(1'b1, 3'h7);
        op(3'h1, 17'h01FFF, 16'h0000);
        chk({15'h0000, o_error}, 16'h0001, "locked program");
        rd_chk(17'h01FFF, 16'hFFFF);
        op(3'h1, 17'h02000, 16'h1111);
        rd_chk(17'h02000, 16'h1111);
    endtask
    task automatic t_sectors();
        op(3'h1, 17'h04010, 16'h3C3C);
        op(3'h3, 17'h03000, 16'h0000);
        rd_chk(17'h02000, 16'hFFFF);
        rd_chk(17'h04010, 16'h3C3C);
        op(3'h3, 17'h05000, 16'h0000);
        rd_chk(17'h04010, 16'hFFFF);
        t_main_erase(1'b1);
        op(3'h1, 17'h02000, 16'h0F0F);
        op(3'h2, 17'h02000, 16'h0000);
        chk({15'h0000, o_error}, 16'h0000, "chip erase error");
        rd_chk(17'h02000, 16'hFFFF);
        rd_chk(17'h00100, 16'h5A5A);
    endtask
    task automatic t_freeze();
        @(posedge i_core_clk);
        i_clk_en <= 1'b0;
        i_req <= 1'b1;
        i_op <= 3'h0;
        i_addr <= 17'h00100;
        repeat (4) @(posedge i_core_clk);
        i_clk_en <= 1'b1;
        i_req <= 1'b0;
        @(negedge i_core_clk);
        chk({15'h0000, o_ready}, 16'h0001, "taken while frozen");
    endtask
    task automatic t_flash_reset();
        int n;
        n = 0;
        @(posedge i_core_clk);
        i_flash_rst_req <= 1'b1;
        while (o_flash_reset_n !== 1'b0) begin
            @(negedge i_core_clk);
            if (++n > 100) fail("reset pulse");
        end
        @(posedge i_core_clk);
        i_flash_rst_req <= 1'b0;
        n = 0;
        while (o_flash_reset_n !== 1'b1) begin
            @(negedge i_core_clk);
            if (++n > 300) fail("reset release");
        end
        chk({15'h0000, n >= 48}, 16'h0001, "reset width");
        rd_chk(17'h00100, 16'h5A5A);
    endtask
    initial begin
        repeat (20) @(posedge i_core_clk);
        chk({13'h0000, o_flash_reset_n, o_flash_we_n, o_data_pins_oe},
            16'h0002, "pins in reset");
        i_rst_n <= 1'b1;
        t_program();
        op(3'h1, 17'h00100, 16'h5A5A);
        t_main_erase(1'b0);
        t_ident(1'b0, 3'h6);
        t_lock();
        t_sectors();
        t_freeze();
        t_flash_reset();
        results();
    end
endmodule // tb
